/* ltcd_pkg.sv */
/*
  Shared constants for the loop test command decoder: message header
  layout, message type octets, field positions and generator settings.
  Assumes octets arrive most significant bit first in bit 7, with the
  documented bit 1 held in bit 0.
*/
package ltcd_pkg;

  // Header octet: protocol discriminator low nibble, skip indicator high
  localparam logic [3:0] PD_TEST       = 4'hf;
  localparam logic [3:0] SKIP_NONE     = 4'h0;
  localparam int         PD_LSB        = 0;
  localparam int         SKIP_LSB      = 4;

  // Message type octets
  localparam logic [7:0] MT_OPEN_LOOP  = 8'h22;
  localparam logic [7:0] MT_OPEN_ACK   = 8'h23;
  localparam logic [7:0] MT_LINK_DEACT = 8'h10;
  localparam logic [7:0] MT_TEST_PATH  = 8'h14;
  localparam logic [7:0] MT_PKT_TEST   = 8'h24;
  localparam logic [7:0] ACK_HDR       = {SKIP_NONE, PD_TEST};

  // Octet positions inside a message
  localparam int         OCT_HDR       = 0;
  localparam int         OCT_TYPE      = 1;
  localparam int         OCT_PATH      = 2;
  localparam int         OCT_PDU_HI    = 2;
  localparam int         OCT_PDU_LO    = 3;
  localparam int         OCT_MODE      = 4;
  localparam int         MSG_MAX       = 5;
  localparam logic [2:0] LEN_PATH      = 3'h3;
  localparam logic [2:0] LEN_PKT       = 3'h5;
  localparam logic [2:0] LEN_PLAIN     = 3'h2;

  // Tested path codes
  localparam logic [2:0] PATH_NORMAL   = 3'h0;
  localparam logic [2:0] PATH_DL_DEC   = 3'h1;
  localparam logic [2:0] PATH_UL_ENC   = 3'h2;
  localparam logic [2:0] PATH_ACOUSTIC = 3'h4;

  // Packet test fields
  localparam int         LEN_TYPE_BIT  = 7;
  localparam int         CNT_W         = 12;
  localparam int         MODE_LOOP_BIT = 0;
  localparam int         TS_LSB        = 1;
  localparam int         PDU_LEN_MIN   = 140;
  localparam int         PDU_LEN_MAX   = 1560;
  localparam int         LEN_W         = 11;

  // Pseudorandom generator
  localparam int         PRBS_W        = 15;
  localparam logic [14:0] PRBS_SEED    = 15'h7fff;

endpackage

/* ltcd_gen_if.sv */
/*
  Interface between the command decoder and the PDU generator.
  Assumes both ends run on the same clock; no crossing inside.
*/
`timescale 1ns/1ps
interface ltcd_gen_if;
  import ltcd_pkg::*;
  logic             start;    // Load count and begin
  logic [CNT_W-1:0] count;    // PDUs to send
  logic             infinite; // Ignore the count
  logic             busy;     // Generator running
  logic             valid;    // Octet available
  logic             ready;    // Octet taken
  logic [7:0]       data;     // Generated octet
  logic             last;     // Last octet of a PDU

  modport ctrl (output start, count, infinite, ready,
                input  busy, valid, data, last);
  modport gen  (input  start, count, infinite, ready,
                output busy, valid, data, last);
endinterface

/* ltcd_pdu_gen.sv */
/*
  Generates test PDUs made only of pseudorandom octets, fixed length,
  a loaded number of them or without end.
  Assumes the drain side holds ready as it likes; octets stall with it.
*/
`timescale 1ns/1ps
module ltcd_pdu_gen
  import ltcd_pkg::*;
#(
  parameter int PDU_LEN = PDU_LEN_MAX  // Octets per PDU
) (
  input  wire logic i_sys_clk,  // System clock
  input  wire logic i_rst,      // Synchronous reset, high
  ltcd_gen_if.gen   gen         // Decoder side
);

  typedef enum logic {G_IDLE, G_RUN} ltcd_gen_t;

  ltcd_gen_t         state;
  logic [CNT_W-1:0]  remaining;
  logic              endless;
  logic [LEN_W-1:0]  octet;
  logic [PRBS_W-1:0] prbs;

  // Eight shifts of the x^15 + x^14 + 1 register per octet
  function automatic logic [PRBS_W-1:0] ltcd_prbs8(
      input logic [PRBS_W-1:0] s);
    logic [PRBS_W-1:0] r;
    r = s;
    for (int i = 0; i < 8; i++) begin
      r = {r[PRBS_W-2:0], r[PRBS_W-1] ^ r[PRBS_W-2]};
    end
    return r;
  endfunction

  // Payload is the sequence alone, no header or check octets
  assign gen.busy  = (state == G_RUN);
  assign gen.valid = (state == G_RUN);
  assign gen.data  = prbs[7:0];
  assign gen.last  = (state == G_RUN) && (octet == LEN_W'(PDU_LEN - 1));

  // Count of PDUs and octets; a new start restarts the sequence
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state     <= G_IDLE;
      remaining <= '0;
      endless   <= 1'b0;
      octet     <= '0;
      prbs      <= PRBS_SEED;
    end else if (gen.start) begin
      if (gen.count != '0 || gen.infinite) begin
        state <= G_RUN;
      end else begin
        state <= G_IDLE;
      end
      remaining <= gen.count;
      endless   <= gen.infinite;
      octet     <= '0;
      prbs      <= PRBS_SEED;
    end else if (state == G_RUN && gen.ready) begin
      prbs <= ltcd_prbs8(prbs);
      if (gen.last) begin
        octet <= '0;
        if (!endless) begin
          remaining <= remaining - 1'b1;
          if (remaining == 12'h001) begin
            state <= G_IDLE;
          end
        end
      end else begin
        octet <= octet + 1'b1;
      end
    end
  end

  // Last octet of the last counted PDU ends the run
  a_gen_stop: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    gen.last && gen.ready && !endless && remaining == 12'h001 && !gen.start
    |=> !gen.busy)
    else $error("generator ran past its PDU count");

  c_gen_pdu_end: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    gen.last && gen.ready);

endmodule // ltcd_pdu_gen

/* ltcd_decoder.sv */
/*
  Loop test command decoder: collects one test message per frame,
  decodes it and drives the test controls, the acknowledge stream and
  the packet test data path.
  Assumes messages arrive one octet a cycle on the system clock from the
  link layer, framed by i_rx_last, and that acks drain via i_ack_ready.
*/
// What this block does
// - A message whose skip indicator is not zero is dropped without action or ack.
// - Only messages carrying the test protocol discriminator 1111 are acted on, and acks carry it too.
// - The low three bits of the path octet select normal, downlink decoder, uplink encoder or acoustic test.
// - Any other path code is refused and the previous selection is kept.
// - The PDU description is applied only when the device generates the data itself.
// - Generated PDUs hold only pseudorandom octets, with no header and no check field.
// - The top bit of the first description octet set means fixed length PDUs; cleared is reserved and ignored.
// - The supported PDU length is a fixed parameter of the design.
// - The PDU count is twelve bits, low nibble of the first octet over the whole second octet.
// - A zero count may, by parameter, mean PDUs without end.
// - With both data sources built, mode bit 1 at zero selects internal generation.
// - With both data sources built, mode bit 1 at one loops received data back.
// - Mode bits 4 to 2 give the downlink timeslot offset.
`timescale 1ns/1ps
module ltcd_decoder
  import ltcd_pkg::*;
#(
  parameter int   PDU_LEN          = PDU_LEN_MAX, // Octets per PDU
  parameter logic SUPPORTS_BOTH    = 1'b1,        // Loop and generator
  parameter logic ZERO_IS_INFINITE = 1'b1         // Zero count endless
) (
  input  wire logic       i_sys_clk,          // 40 MHz system clock
  input  wire logic       i_rst,              // Synchronous reset, high
  input  wire logic       i_rx_valid,         // Message octet valid
  input  wire logic [7:0] i_rx_data,          // Message octet
  input  wire logic       i_rx_last,          // Last octet of message
  output logic            o_ack_valid,        // Ack octet valid
  output logic [7:0]      o_ack_data,         // Ack octet
  output logic            o_ack_last,         // Last ack octet
  input  wire logic       i_ack_ready,        // Ack octet taken
  output logic            o_loop_open,        // Open loop pulse
  output logic            o_test_link_active, // Test link enabled
  output logic [2:0]      o_test_path,        // Selected test path
  output logic            o_path_reject,      // Reserved path pulse
  output logic            o_packet_mode,      // Packet test entered
  output logic            o_loopback_sel,     // Loop received data
  output logic [2:0]      o_dl_ts_offset,     // Downlink slot offset
  input  wire logic       i_loop_valid,       // Received data valid
  input  wire logic [7:0] i_loop_data,        // Received data octet
  output logic            o_tx_valid,         // Transmit octet valid
  output logic [7:0]      o_tx_data,          // Transmit octet
  output logic            o_tx_last,          // Last octet of PDU
  input  wire logic       i_tx_ready,         // Transmit octet taken
  output logic            o_gen_busy          // Generator running
);

  typedef enum logic [1:0] {A_IDLE, A_HDR, A_TYPE} ltcd_ack_t;

  ltcd_gen_if gen_if ();

  logic [7:0] msg [MSG_MAX];
  logic [2:0] wr_idx;
  logic [2:0] msg_len;
  logic       msg_done;
  ltcd_ack_t  ack_state;
  logic       loop_valid;
  logic [7:0] loop_data;

  logic             hdr_ok;
  logic             is_open;
  logic             is_deact;
  logic             is_path;
  logic             is_pkt;
  logic             loop_req;
  logic             pkt_start;
  logic [2:0]       path_code;
  logic [CNT_W-1:0] pdu_count;

  // Only the four defined selections count as a path
  function automatic logic ltcd_path_legal(input logic [2:0] code);
    return code == PATH_NORMAL || code == PATH_DL_DEC ||
           code == PATH_UL_ENC || code == PATH_ACOUSTIC;
  endfunction

  // Message capture; octets past the fifth are dropped, not wrapped
  always_ff @(posedge i_sys_clk) begin
    if (i_rx_valid && wr_idx < 3'(MSG_MAX)) begin
      msg[wr_idx] <= i_rx_data;
    end
  end

  // Frame position and end-of-message strobe
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_idx   <= '0;
      msg_len  <= '0;
      msg_done <= 1'b0;
    end else begin
      msg_done <= i_rx_valid && i_rx_last;
      if (i_rx_valid) begin
        if (i_rx_last) begin
          wr_idx  <= '0;
          msg_len <= (wr_idx < 3'(MSG_MAX)) ? wr_idx + 1'b1 : wr_idx;
        end else if (wr_idx < 3'(MSG_MAX)) begin
          wr_idx <= wr_idx + 1'b1;
        end
      end
    end
  end

  // Header check gates every command; short messages are ignored
  assign hdr_ok    = msg_done && msg_len >= LEN_PLAIN &&
                     msg[OCT_HDR][SKIP_LSB+:4] == SKIP_NONE &&
                     msg[OCT_HDR][PD_LSB+:4] == PD_TEST;
  assign is_open   = hdr_ok && msg[OCT_TYPE] == MT_OPEN_LOOP;
  assign is_deact  = hdr_ok && msg[OCT_TYPE] == MT_LINK_DEACT;
  assign is_path   = hdr_ok && msg[OCT_TYPE] == MT_TEST_PATH &&
                     msg_len >= LEN_PATH;
  assign is_pkt    = hdr_ok && msg[OCT_TYPE] == MT_PKT_TEST &&
                     msg_len >= LEN_PKT;
  assign path_code = msg[OCT_PATH][2:0];
  assign pdu_count = {msg[OCT_PDU_HI][3:0], msg[OCT_PDU_LO]};
  // A generator-only build ignores the source bit
  assign loop_req  = SUPPORTS_BOTH &&
                     msg[OCT_MODE][MODE_LOOP_BIT];
  // Description used only for own data and fixed length type
  assign pkt_start = is_pkt && !loop_req &&
                     msg[OCT_PDU_HI][LEN_TYPE_BIT];

  assign gen_if.start    = pkt_start;
  assign gen_if.count    = pdu_count;
  assign gen_if.infinite = ZERO_IS_INFINITE && pdu_count == '0;
  assign gen_if.ready    = i_tx_ready && !o_loopback_sel;

  // Acknowledge stream; an open arriving mid-ack gets no second ack
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ack_state  <= A_IDLE;
      o_ack_data <= '0;
    end else begin
      unique case (ack_state)
        A_IDLE: begin
          if (is_open) begin
            ack_state  <= A_HDR;
            o_ack_data <= ACK_HDR;
          end
        end
        A_HDR: begin
          if (i_ack_ready) begin
            ack_state  <= A_TYPE;
            o_ack_data <= MT_OPEN_ACK;
          end
        end
        A_TYPE: begin
          if (i_ack_ready) begin
            ack_state <= A_IDLE;
          end
        end
      endcase
    end
  end

  assign o_ack_valid = (ack_state != A_IDLE);
  assign o_ack_last  = (ack_state == A_TYPE);

  // Loop opening and test link control
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_loop_open        <= 1'b0;
      o_test_link_active <= 1'b1;
    end else begin
      o_loop_open <= is_open;
      if (is_deact) begin
        o_test_link_active <= 1'b0;
      end
    end
  end

  // Path selection; reserved codes leave the old path in place
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_test_path   <= PATH_NORMAL;
      o_path_reject <= 1'b0;
    end else begin
      o_path_reject <= is_path && !ltcd_path_legal(path_code);
      if (is_path && ltcd_path_legal(path_code)) begin
        o_test_path <= path_code;
      end
    end
  end

  // Packet test mode settings from the mode flag octet
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_packet_mode  <= 1'b0;
      o_loopback_sel <= 1'b0;
      o_dl_ts_offset <= '0;
    end else if (is_pkt) begin
      o_packet_mode  <= 1'b1;
      o_loopback_sel <= loop_req;
      o_dl_ts_offset <= msg[OCT_MODE][TS_LSB+:3];
    end
  end

  // Loopback path has no buffer: octets not taken at once are lost
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      loop_valid <= 1'b0;
      loop_data  <= '0;
    end else begin
      loop_valid <= i_loop_valid && o_packet_mode && o_loopback_sel;
      loop_data  <= i_loop_data;
    end
  end

  assign o_tx_valid = o_loopback_sel ? loop_valid : gen_if.valid;
  assign o_tx_data  = o_loopback_sel ? loop_data  : gen_if.data;
  assign o_tx_last  = !o_loopback_sel && gen_if.last;
  assign o_gen_busy = gen_if.busy;

  // Length fixed at build time; nothing checks it against the documented span
  ltcd_pdu_gen #(
    .PDU_LEN (PDU_LEN)
  ) u_pdu_gen (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .gen       (gen_if.gen)
  );

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_skip_discard: assert property (
    msg_done && msg[OCT_HDR][SKIP_LSB+:4] != SKIP_NONE && ack_state == A_IDLE
    |=> ack_state == A_IDLE && !o_loop_open && $stable(o_test_path))
    else $error("message with skip indicator was acted on");
  a_pd_filter: assert property (
    msg_done && msg[OCT_HDR][PD_LSB+:4] != PD_TEST
    |=> $stable(o_test_link_active) && $stable(o_packet_mode) && !o_loop_open)
    else $error("non-test discriminator was acted on");
  a_open_ack_hdr: assert property (
    is_open && ack_state == A_IDLE
    |=> o_ack_valid && o_ack_data == ACK_HDR && !o_ack_last)
    else $error("open loop ack header wrong");
  // Header taken moves straight on to the type octet, however long it waited
  a_open_ack_type: assert property (
    o_ack_valid && !o_ack_last && i_ack_ready
    |=> o_ack_valid && o_ack_last && o_ack_data == MT_OPEN_ACK)
    else $error("open loop ack type octet wrong");
  a_path_select: assert property (
    is_path && ltcd_path_legal(path_code)
    |=> o_test_path == $past(path_code) && !o_path_reject)
    else $error("legal path not applied");
  a_path_refuse: assert property (
    is_path && !ltcd_path_legal(path_code)
    |=> o_path_reject && $stable(o_test_path))
    else $error("reserved path code accepted");
  a_desc_gate: assert property (
    is_pkt && loop_req && !o_gen_busy |=> !o_gen_busy)
    else $error("description applied in loopback mode");
  a_len_type: assert property (
    is_pkt && !msg[OCT_PDU_HI][LEN_TYPE_BIT] && !o_gen_busy
    |=> !o_gen_busy)
    else $error("generator started with reserved length type");
  a_count_load: assert property (
    gen_if.start && pdu_count != '0 |=> o_gen_busy)
    else $error("nonzero count did not start generator");
  a_src_select: assert property (
    is_pkt |=> o_loopback_sel == (SUPPORTS_BOTH && $past(msg[OCT_MODE][0]))
               && o_packet_mode)
    else $error("data source select not applied");
  a_ts_offset: assert property (
    is_pkt |=> o_dl_ts_offset == $past(msg[OCT_MODE][3:1]))
    else $error("timeslot offset not applied");
  a_deact_link: assert property (
    is_deact |=> !o_test_link_active [*2])
    else $error("test link stayed active after deactivate");
  // Looped octet reaches the transmitter one cycle later, unchanged
  a_loop_data: assert property (
    i_loop_valid && o_packet_mode && o_loopback_sel && !is_pkt
    |=> o_tx_valid && o_tx_data == $past(i_loop_data))
    else $error("looped octet not passed to transmitter");
  a_ack_hold: assert property (
    o_ack_valid && !i_ack_ready |=> o_ack_valid && $stable(o_ack_data))
    else $error("ack octet dropped before it was taken");

  c_open_ack: cover property (is_open ##1 o_ack_valid [*2]);
  c_path_set: cover property (is_path ##1 o_test_path == PATH_ACOUSTIC);
  c_pkt_gen: cover property (gen_if.start ##[1:20] o_tx_valid);
  c_pkt_loop: cover property (is_pkt && loop_req ##[1:20] loop_valid);

endmodule // ltcd_decoder

/* ltcd_sim_model.sv */
/*
  Behavioural model of the test simulator at the far side: it sends
  framed test messages, drains acks and generated octets, and feeds
  received data for loopback.
  Assumes one shared clock; i_slow makes both drains stall.
*/
`timescale 1ns/1ps
module ltcd_sim_model (
  input  wire logic       i_sys_clk,    // System clock
  input  wire logic       i_slow,       // Stall both drains
  output logic            o_rx_valid,   // Message octet valid
  output logic [7:0]      o_rx_data,    // Message octet
  output logic            o_rx_last,    // Last message octet
  input  wire logic       i_ack_valid,  // Ack octet valid
  input  wire logic [7:0] i_ack_data,   // Ack octet
  input  wire logic       i_ack_last,   // Last ack octet
  output logic            o_ack_ready,  // Ack octet taken
  output logic            o_loop_valid, // Received data valid
  output logic [7:0]      o_loop_data,  // Received data octet
  input  wire logic       i_tx_valid,   // Transmit octet valid
  input  wire logic [7:0] i_tx_data,    // Transmit octet
  input  wire logic       i_tx_last,    // Last PDU octet
  output logic            o_tx_ready    // Transmit octet taken
);
  logic       phase;
  logic [7:0] ack_q[$];
  logic       ack_last_q[$];
  int         n_tx;
  int         n_last;
  logic [7:0] first_tx;
  int         since_cmd;  // Cycles since a command went out
  int         since_loop; // Cycles since a loop octet went out
  int         ack_wait;   // Command timer at the first ack octet
  int         tx_wait;    // Command timer at the first tx octet
  int         loop_wait;  // Loop timer at the first tx octet

  initial begin
    phase        = 1'b0;
    o_rx_valid   = 1'b0;
    o_rx_data    = 8'h00;
    o_rx_last    = 1'b0;
    o_loop_valid = 1'b0;
    o_loop_data  = 8'h00;
    n_tx         = 0;
    n_last       = 0;
    first_tx     = 8'h00;
    since_cmd    = 0;
    since_loop   = 0;
    ack_wait     = 2147483647;
    tx_wait      = 2147483647;
    loop_wait    = 2147483647;
  end

  // Slow mode takes every other octet, a far side that lags
  always @(posedge i_sys_clk) phase <= ~phase;
  assign o_ack_ready = ~i_slow | phase;
  assign o_tx_ready  = ~i_slow | phase;

  // Record acks and octets as taken; supervision timers read first,
  // then move, so one process owns them and no race arises
  always @(posedge i_sys_clk) begin
    if (i_ack_valid && o_ack_ready) begin
      if (ack_q.size() == 0) ack_wait = since_cmd;
      ack_q.push_back(i_ack_data);
      ack_last_q.push_back(i_ack_last);
    end
    if (i_tx_valid && o_tx_ready) begin
      if (n_tx == 0) begin
        first_tx  = i_tx_data;
        tx_wait   = since_cmd;
        loop_wait = since_loop;
      end
      n_tx = n_tx + 1;
      if (i_tx_last) n_last = n_last + 1;
    end
    since_cmd  = (o_rx_valid && o_rx_last) ? 0 : since_cmd + 1;
    since_loop = o_loop_valid ? 0 : since_loop + 1;
  end

  // One octet a cycle; idle data inverted so stale values never match
  task send_msg(input logic [7:0] m[$]);
    for (int i = 0; i < m.size(); i++) begin
      @(posedge i_sys_clk);
      o_rx_valid <= 1'b1;
      o_rx_data  <= m[i];
      o_rx_last  <= (i == m.size() - 1);
    end
    @(posedge i_sys_clk);
    o_rx_valid <= 1'b0;
    o_rx_last  <= 1'b0;
    o_rx_data  <= ~m[m.size() - 1];
  endtask

  // A single received octet for the loop path
  task send_loop(input logic [7:0] d);
    @(posedge i_sys_clk);
    o_loop_valid <= 1'b1;
    o_loop_data  <= d;
    @(posedge i_sys_clk);
    o_loop_valid <= 1'b0;
    o_loop_data  <= ~d;
  endtask
endmodule // ltcd_sim_model

/* loop_test_command_decoder_tb_top.sv */
/*
  Self-checking bench for the loop test command decoder, one task per
  scenario, driving through the simulator model.
  Assumes a short PDU length so long transfers stay quick.
*/
`timescale 1ns/1ps
module loop_test_command_decoder_tb_top;
  import ltcd_pkg::*;
  localparam int LEN = 4; // Short PDUs keep runs brief
  localparam int SUP_LONG  = 100000000; // 2.5 s of 25 ns cycles
  localparam int SUP_SHORT = 2000000;   // 50 ms of 25 ns cycles
  logic       i_sys_clk;
  logic       i_rst;
  logic       slow;
  logic       rx_v, rx_l, ack_v, ack_l, ack_r, lp_v;
  logic       tx_v, tx_l, tx_r;
  logic [7:0] rx_d, ack_d, lp_d, tx_d;
  logic       lopen, link, rej, pkt, lsel, busy;
  logic [2:0] path, ts;
  int         n_mismatch;
  int         n_checks;
  int         k;

  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  ltcd_decoder #(.PDU_LEN(LEN)) dut (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_rx_valid(rx_v),
    .i_rx_data(rx_d), .i_rx_last(rx_l), .o_ack_valid(ack_v),
    .o_ack_data(ack_d), .o_ack_last(ack_l), .i_ack_ready(ack_r),
    .o_loop_open(lopen), .o_test_link_active(link),
    .o_test_path(path), .o_path_reject(rej), .o_packet_mode(pkt),
    .o_loopback_sel(lsel), .o_dl_ts_offset(ts), .i_loop_valid(lp_v),
    .i_loop_data(lp_d), .o_tx_valid(tx_v), .o_tx_data(tx_d),
    .o_tx_last(tx_l), .i_tx_ready(tx_r), .o_gen_busy(busy));

  ltcd_sim_model sim (
    .i_sys_clk(i_sys_clk), .i_slow(slow), .o_rx_valid(rx_v),
    .o_rx_data(rx_d), .o_rx_last(rx_l), .i_ack_valid(ack_v),
    .i_ack_data(ack_d), .i_ack_last(ack_l), .o_ack_ready(ack_r),
    .o_loop_valid(lp_v), .o_loop_data(lp_d), .i_tx_valid(tx_v),
    .i_tx_data(tx_d), .i_tx_last(tx_l), .o_tx_ready(tx_r));

  task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Counts loop-open pulses over a short window after a command
  task open_pulses(input logic [7:0] hdr, output int n);
    n = 0;
    sim.send_msg('{hdr, MT_OPEN_LOOP});
    repeat (8) begin
      @(negedge i_sys_clk);
      if (lopen === 1'b1) n++;
    end
  endtask

  task wait_idle;
    repeat (2) @(negedge i_sys_clk);
    for (k = 0; k < 4000 && busy !== 1'b0; k++) @(negedge i_sys_clk);
    chk("idle", 12'h0, busy);
  endtask

  task t_reset;
    chk("link", 12'h1, link);
    chk("path", 12'h0, path);
    chk("pkt", 12'h0, pkt);
    chk("ackv", 12'h0, ack_v);
    chk("busy", 12'h0, busy);
  endtask

  // Open loop while the ack drain stalls
  task t_open;
    int n;
    @(posedge i_sys_clk);
    slow <= 1'b1;
    open_pulses({SKIP_NONE, PD_TEST}, n);
    chk("open", 12'h1, n);
    chk("nack", 12'h2, sim.ack_q.size());
    chk("ack0", ACK_HDR, sim.ack_q[0]);
    chk("ack1", MT_OPEN_ACK, sim.ack_q[1]);
    chk("alst", 12'h1, sim.ack_last_q[1]);
    chk("tt1", 12'h1, sim.ack_wait < SUP_LONG);
    sim.ack_q.delete();
    @(posedge i_sys_clk);
    slow <= 1'b0;
  endtask

  // Non-zero skip and foreign discriminator are dropped
  task t_drop;
    int n;
    open_pulses(8'h1f, n);
    chk("skip", 12'h0, n);
    open_pulses(8'h0e, n);
    chk("pd", 12'h0, n);
    chk("nack", 12'h0, sim.ack_q.size());
  endtask

  task path_cmd(input logic [2:0] c);
    sim.send_msg('{ACK_HDR, MT_TEST_PATH, {5'h00, c}});
  endtask

  task t_path;
    logic [2:0] codes[4];
    int n;
    codes = '{PATH_DL_DEC, PATH_UL_ENC, PATH_NORMAL, PATH_ACOUSTIC};
    foreach (codes[i]) begin
      path_cmd(codes[i]);
      repeat (3) @(negedge i_sys_clk);
      chk("path", codes[i], path);
    end
    // Reserved codes pulse reject and leave the path alone
    n = 0;
    path_cmd(3'h3);
    repeat (4) begin
      @(negedge i_sys_clk);
      if (rej === 1'b1) n++;
    end
    chk("rej", 12'h1, n);
    chk("kept", PATH_ACOUSTIC, path);
  endtask

  task t_deact;
    sim.send_msg('{ACK_HDR, MT_LINK_DEACT});
    repeat (3) @(negedge i_sys_clk);
    chk("link", 12'h0, link);
  endtask

  task pkt_cmd(input logic [7:0] hi, lo, mode);
    sim.n_tx = 0;
    sim.n_last = 0;
    sim.send_msg('{ACK_HDR, MT_PKT_TEST, hi, lo, mode});
  endtask

  // Count 2 and a count using the upper nibble, slow drain
  task t_gen;
    pkt_cmd(8'h80, 8'h02, 8'h0a);
    wait_idle();
    chk("pkt", 12'h1, pkt);
    chk("ts5", 12'h5, ts);
    chk("lsel", 12'h0, lsel);
    chk("ntx", 2 * LEN, sim.n_tx);
    chk("nlast", 12'h2, sim.n_last);
    chk("first", 12'h0ff, sim.first_tx);
    chk("tt2", 12'h1, sim.tx_wait < SUP_LONG);
    @(posedge i_sys_clk);
    slow <= 1'b1;
    pkt_cmd(8'h81, 8'h01, 8'h0e);
    wait_idle();
    chk("ts7", 12'h7, ts);
    chk("nlast", 12'h101, sim.n_last);
    chk("ntx", 12'h101 * LEN, sim.n_tx);
    @(posedge i_sys_clk);
    slow <= 1'b0;
  endtask

  // Cleared length type: mode applies, no PDUs
  task t_rsvd_len;
    pkt_cmd(8'h01, 8'h01, 8'h00);
    repeat (10) @(negedge i_sys_clk);
    chk("busy", 12'h0, busy);
    chk("ts0", 12'h0, ts);
  endtask

  task t_infinite;
    pkt_cmd(8'h80, 8'h00, 8'h00);
    repeat (60) @(negedge i_sys_clk);
    chk("busy", 12'h1, busy);
    chk("more", 12'h1, sim.n_tx > 40);
    pkt_cmd(8'h80, 8'h01, 8'h00);
    wait_idle();
    chk("stop", 12'h0, busy);
  endtask

  // Loop select ignores the PDU description
  task t_loop;
    pkt_cmd(8'h80, 8'h05, 8'h01);
    repeat (3) @(negedge i_sys_clk);
    chk("lsel", 12'h1, lsel);
    chk("busy", 12'h0, busy);
    sim.send_loop(8'h5a);
    @(negedge i_sys_clk);
    chk("txv", 12'h1, tx_v);
    chk("txd", 12'h05a, tx_d);
    chk("txl", 12'h0, tx_l);
    @(negedge i_sys_clk);
    chk("loop", 12'h05a, sim.first_tx);
    chk("tt3", 12'h1, sim.loop_wait < SUP_SHORT);
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hang guard well beyond the longest transfer
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    n_mismatch = 0;
    n_checks   = 0;
    i_rst      = 1'b1;
    slow       = 1'b0;
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(negedge i_sys_clk);
    t_reset();
    t_open();
    t_drop();
    t_path();
    t_deact();
    t_gen();
    t_rsvd_len();
    t_infinite();
    t_loop();
    end_of_test();
  end
endmodule // loop_test_command_decoder_tb_top
